// *** inc/flash_sec_pkg.sv ***
/*
  Constants shared by the flash security and command entry front end.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package flash_sec_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] PROT_OFFS   = 8'h00;
  localparam logic [7:0] INDEX_OFFS  = 8'h04;
  localparam logic [7:0] PARAM_OFFS  = 8'h08;
  localparam logic [7:0] STATUS_OFFS = 8'h0C;
  localparam logic [7:0] INTST_OFFS  = 8'h10;
  localparam logic [7:0] INTMSK_OFFS = 8'h14;

  // Protection byte layout and codes.
  localparam int         PERMIT_HI   = 7;
  localparam int         PERMIT_LO   = 6;
  localparam int         LOCK_HI     = 1;
  localparam int         LOCK_LO     = 0;
  localparam logic [1:0] PERMIT_ON   = 2'h2;
  localparam logic [1:0] UNLOCKED    = 2'h2;
  localparam logic [7:0] PROT_FAULT  = 8'hFF;
  localparam logic [7:0] PROT_RESET  = 8'hFF;

  // Nonvolatile address of the security byte.
  localparam logic [17:0] SEC_BYTE_ADDR = 18'h3FF0F;

  // Parameter array shape.
  localparam int         PARAM_WORDS = 6;
  localparam logic [2:0] IDX_CMD     = 3'h0;
  localparam logic [2:0] IDX_ADDR    = 3'h1;
  localparam logic [2:0] IDX_DATA0   = 3'h2;
  localparam logic [2:0] IDX_RESET   = 3'h0;

  // Status register: completion flag position and reset value.
  localparam int         COMMAND_COMPLETE_FLAG_BIT    = 7;
  localparam logic       COMMAND_COMPLETE_FLAG_RESET  = 1'b1;

  // Interrupt status and mask bits.
  localparam int         INT_DONE    = 0;
  localparam int         INT_LOADED  = 1;
  localparam logic [1:0] INT_RESET   = 2'h0;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_READ = 2'b01,
    LD_DONE = 2'b11
  } load_state_e;

endpackage : flash_sec_pkg

// *** hdl/security_byte_loader.sv ***
/*
  Fetches the nonvolatile security byte once after reset.
  Assumes the flash array answers a read request with a valid strobe.
*/
`timescale 1ns/1ns
module security_byte_loader
  import flash_sec_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  nvmByte,
  input  wire logic        nvmDoubleFault,
  input  wire logic        nvmValid,
  output logic             nvmReq,
  output logic [17:0]      nvmAddr,
  output logic [7:0]       secByte,
  output logic             loadPulse
);

  typedef struct packed {
    load_state_e state;
    logic        req;
    logic [7:0]  value;
    logic        pulse;
    logic [17:0] addr;
  } load_s;

  load_s cur;
  load_s nxt;

  always_comb begin
    nxt       = cur;
    nxt.pulse = 1'b0;
    case (cur.state)
      LD_IDLE: begin
        nxt.state = LD_READ;
        nxt.req   = 1'b1;
      end
      LD_READ: begin
        if (nvmValid) begin
          nxt.req   = 1'b0;
          nxt.state = LD_DONE;
          nxt.pulse = 1'b1;
          // A double fault leaves the part secured with no backdoor.  // see R03
          nxt.value = nvmDoubleFault ? PROT_FAULT : nvmByte;  // see R02
        end
      end
      LD_DONE: begin
        nxt.state = LD_DONE;
      end
      default: begin
        nxt.state = LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // The fetch address is held in a flop so that every top output is registered.
      cur <= '{state: LD_IDLE, req: 1'b0, value: PROT_RESET, pulse: 1'b0,
               addr: SEC_BYTE_ADDR};
    end else begin
      cur <= nxt;
    end
  end

  assign nvmReq    = cur.req;
  assign nvmAddr   = cur.addr;
  assign secByte   = cur.value;
  assign loadPulse = cur.pulse;

endmodule : security_byte_loader

// *** hdl/flash_security_and_command_entry.sv ***
/*
  Security configuration and command entry front end of a flash controller,
  reached over AXI4-Lite. Assumes the command engine answers with a
  completion pulse and may return results into the parameter array.
*/
// Design decisions made here: the register addresses and register access over AXI4-Lite.
// What this block does
// R01 - Protection register is readable; software writes to it are ignored.
// R02 - Protection register loads from the nonvolatile security byte after reset.
// R03 - Double fault on that read sets all protection bits.
// R04 - Backdoor access enabled only when permit field bits 7-6 equal 10.
// R05 - Part unsecured only when lock field bits 1-0 equal 10.
// R06 - Backdoor unlock forces the lock field to the unsecured code.
// R07 - Software keeps reserved bits 5-2 erased.
// R08 - Index register: three index bits read/write, others read zero.
// R09 - Fill parameters, then write one to completion flag; flag clears.
// R10 - Parameters locked while running; completion sets the flag again.
// R11 - Results land in parameter array; read them after the flag returns.
// R12 - Indices 110 and 111 ignore writes and read 0x0000.
// R13 - High byte at index 000 holds the command code.
// R14 - Index 000 low byte holds address 17-16; 001 address; 010 data.
// R15 - Writing zero to the completion flag does nothing.
`timescale 1ns/1ns
module flash_security_and_command_entry
  import flash_sec_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        nvmByte,
  input  wire logic              nvmDoubleFault,
  input  wire logic              nvmValid,
  output logic                   nvmReq,
  output logic [17:0]            nvmAddr,
  input  wire logic              backdoorUnlock,
  input  wire logic              cmdDone,
  input  wire logic              resultWe,
  input  wire logic [2:0]        resultIndex,
  input  wire logic [15:0]       resultData,
  output logic                   cmdStart,
  output logic [7:0]             cmdCode,
  output logic [17:0]            cmdAddr,
  output logic [15:0]            cmdData0,
  output logic                   backdoorEnabled,
  output logic                   unsecured,
  output logic                   irq
);

  typedef struct packed {
    logic                        awHave;
    logic [ADDR_W-1:0]           awAddr;
    logic                        wHave;
    logic [31:0]                 wData;
    logic [3:0]                  wStrb;
    logic                        awReady;
    logic                        wReady;
    logic                        bValid;
    logic [1:0]                  bResp;
    logic                        arReady;
    logic                        rValid;
    logic [31:0]                 rData;
    logic [1:0]                  rResp;
    logic [7:0]                  prot;
    logic [2:0]                  index;
    logic [PARAM_WORDS-1:0][15:0] param;
    logic                        command_complete_flag;
    logic                        start;
    logic [1:0]                  intStat;
    logic [1:0]                  intMask;
    logic                        irq;
    logic                        keyOk;
    logic                        unsec;
  } regs_s;

  regs_s cur_ff;
  regs_s nxt_regs;

  logic [7:0] secByte;
  logic       loadPulse;

  security_byte_loader loader (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .nvmByte        (nvmByte),
    .nvmDoubleFault (nvmDoubleFault),
    .nvmValid       (nvmValid),
    .nvmReq         (nvmReq),
    .nvmAddr        (nvmAddr),
    .secByte        (secByte),
    .loadPulse      (loadPulse)
  );

  always_comb begin
    logic [7:0]  wOffs;
    logic [7:0]  rOffs;
    logic        doWrite;
    logic [15:0] word;
    logic [1:0]  clrMask;
    logic [1:0]  setEv;
    logic [31:0] rd;
    logic        hit;
    wOffs   = '0;
    rOffs   = '0;
    doWrite = 1'b0;
    word    = '0;
    clrMask = '0;
    setEv   = '0;
    rd      = '0;
    hit     = 1'b0;
    nxt_regs       = cur_ff;
    nxt_regs.start = 1'b0;
    wOffs   = 8'(cur_ff.awAddr);
    rOffs   = 8'(s_axi_araddr);
    doWrite = cur_ff.awHave && cur_ff.wHave && !cur_ff.bValid;

    // Address and data are taken independently, in either order.
    if (s_axi_awvalid && cur_ff.awReady) begin
      nxt_regs.awHave = 1'b1;
      nxt_regs.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur_ff.wReady) begin
      nxt_regs.wHave = 1'b1;
      nxt_regs.wData = s_axi_wdata;
      nxt_regs.wStrb = s_axi_wstrb;
    end
    if (cur_ff.bValid && s_axi_bready) begin
      nxt_regs.bValid = 1'b0;
    end

    // Results returned by the engine go into the array while it runs.  // see R11
    if (resultWe && !cur_ff.command_complete_flag && resultIndex < 3'(PARAM_WORDS)) begin
      nxt_regs.param[resultIndex] = resultData;
    end

    if (doWrite) begin
      nxt_regs.awHave = 1'b0;
      nxt_regs.wHave  = 1'b0;
      nxt_regs.bValid = 1'b1;
      nxt_regs.bResp  = RESP_OKAY;
      case ({wOffs[7:2], 2'b00})
        PROT_OFFS: begin
          nxt_regs.prot = cur_ff.prot;  // see R01
        end
        INDEX_OFFS: begin
          if (cur_ff.wStrb[0]) begin
            nxt_regs.index = cur_ff.wData[2:0];  // see R08
          end
        end
        PARAM_OFFS: begin
          // Writes are dropped while a command runs or past the array.  // see R10
          if (cur_ff.command_complete_flag && cur_ff.index < 3'(PARAM_WORDS)) begin  // see R12
            word = cur_ff.param[cur_ff.index];
            if (cur_ff.wStrb[0]) begin
              word[7:0] = cur_ff.wData[7:0];
            end
            if (cur_ff.wStrb[1]) begin
              word[15:8] = cur_ff.wData[15:8];
            end
            nxt_regs.param[cur_ff.index] = word;
          end
        end
        STATUS_OFFS: begin
          // Only a one launches; a zero is harmless.  // see R15
          if (cur_ff.wStrb[0] && cur_ff.wData[COMMAND_COMPLETE_FLAG_BIT] && cur_ff.command_complete_flag) begin
            nxt_regs.command_complete_flag  = 1'b0;  // see R09
            nxt_regs.start = 1'b1;
          end
        end
        INTST_OFFS: begin
          if (cur_ff.wStrb[0]) begin
            clrMask = cur_ff.wData[1:0];
          end
        end
        INTMSK_OFFS: begin
          if (cur_ff.wStrb[0]) begin
            nxt_regs.intMask = cur_ff.wData[1:0];
          end
        end
        default: begin
          nxt_regs.bResp = RESP_DECERR;
        end
      endcase
    end

    // The engine can only finish a command that is running.  // see R10
    if (cmdDone && !cur_ff.command_complete_flag) begin
      nxt_regs.command_complete_flag = 1'b1;
    end

    // Security byte load, then a later backdoor unlock overrides the lock.
    if (loadPulse) begin
      nxt_regs.prot = secByte;  // see R02
    end
    if (backdoorUnlock) begin
      nxt_regs.prot[LOCK_HI:LOCK_LO] = UNLOCKED;  // see R06
    end
    nxt_regs.keyOk = (nxt_regs.prot[PERMIT_HI:PERMIT_LO] == PERMIT_ON);  // see R04
    nxt_regs.unsec = (nxt_regs.prot[LOCK_HI:LOCK_LO] == UNLOCKED);  // see R05

    // Sticky events: a set in the clearing cycle wins over the clear.
    setEv[INT_DONE]   = cmdDone && !cur_ff.command_complete_flag;
    setEv[INT_LOADED] = loadPulse;
    nxt_regs.intStat  = (cur_ff.intStat & ~clrMask) | setEv;
    nxt_regs.irq      = |(nxt_regs.intStat & nxt_regs.intMask);

    // Read channel: one read outstanding, answered the cycle after it is taken.
    if (cur_ff.rValid && s_axi_rready) begin
      nxt_regs.rValid = 1'b0;
    end
    if (s_axi_arvalid && cur_ff.arReady) begin
      hit = 1'b1;
      case ({rOffs[7:2], 2'b00})
        PROT_OFFS: begin
          rd[7:0] = cur_ff.prot;  // see R01
        end
        INDEX_OFFS: begin
          rd[2:0] = cur_ff.index;  // see R08
        end
        PARAM_OFFS: begin
          // Software should read results only once the flag has returned.  // see R11
          if (cur_ff.index < 3'(PARAM_WORDS)) begin
            rd[15:0] = cur_ff.param[cur_ff.index];
          end else begin
            rd[15:0] = 16'h0000;  // see R12
          end
        end
        STATUS_OFFS: begin
          rd[COMMAND_COMPLETE_FLAG_BIT] = cur_ff.command_complete_flag;
        end
        INTST_OFFS: begin
          rd[1:0] = cur_ff.intStat;
        end
        INTMSK_OFFS: begin
          rd[1:0] = cur_ff.intMask;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      nxt_regs.rValid = 1'b1;
      nxt_regs.rData  = rd;
      nxt_regs.rResp  = hit ? RESP_OKAY : RESP_DECERR;
    end

    nxt_regs.awReady = !nxt_regs.awHave && !nxt_regs.bValid;
    nxt_regs.wReady  = !nxt_regs.wHave && !nxt_regs.bValid;
    nxt_regs.arReady = !nxt_regs.rValid;
  end

  // Reset holds the part secured until the security byte arrives.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff         <= '0;
      cur_ff.awReady <= 1'b1;
      cur_ff.wReady  <= 1'b1;
      cur_ff.arReady <= 1'b1;
      cur_ff.prot    <= PROT_RESET;
      cur_ff.index   <= IDX_RESET;
      cur_ff.command_complete_flag    <= COMMAND_COMPLETE_FLAG_RESET;
      cur_ff.intStat <= INT_RESET;
      cur_ff.intMask <= INT_RESET;
    end else begin
      cur_ff <= nxt_regs;
    end
  end

  assign s_axi_awready   = cur_ff.awReady;
  assign s_axi_wready    = cur_ff.wReady;
  assign s_axi_bvalid    = cur_ff.bValid;
  assign s_axi_bresp     = cur_ff.bResp;
  assign s_axi_arready   = cur_ff.arReady;
  assign s_axi_rvalid    = cur_ff.rValid;
  assign s_axi_rdata     = cur_ff.rData;
  assign s_axi_rresp     = cur_ff.rResp;
  assign cmdStart        = cur_ff.start;
  assign cmdCode         = cur_ff.param[IDX_CMD][15:8];  // see R13
  assign cmdAddr         = {cur_ff.param[IDX_CMD][1:0], cur_ff.param[IDX_ADDR]};  // see R14
  assign cmdData0        = cur_ff.param[IDX_DATA0];  // see R14
  assign backdoorEnabled = cur_ff.keyOk;
  assign unsecured       = cur_ff.unsec;
  assign irq             = cur_ff.irq;

endmodule : flash_security_and_command_entry

// *** test/flash_security_and_command_entry_asserts.sv ***
/*
  Port checker for the flash security and command entry front end.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module flash_security_and_command_entry_asserts
  import flash_sec_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  nvmByte,
  input wire logic        nvmDoubleFault,
  input wire logic        nvmValid,
  input wire logic        nvmReq,
  input wire logic [17:0] nvmAddr,
  input wire logic        backdoorUnlock,
  input wire logic        cmdStart,
  input wire logic        backdoorEnabled,
  input wire logic        unsecured
);
  logic permitIn;
  logic lockIn;
  assign permitIn = (nvmByte[PERMIT_HI:PERMIT_LO] == PERMIT_ON);
  assign lockIn   = (nvmByte[LOCK_HI:LOCK_LO] == UNLOCKED);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_load;
    nvmReq && nvmValid && !nvmDoubleFault;
  endsequence
  // The unlock input is held off so that only the loaded byte decides the lock field.
  sequence s_load_calm;
    (nvmReq && nvmValid && !nvmDoubleFault && !backdoorUnlock) ##1 !backdoorUnlock [*2];
  endsequence
  chk_fetch_addr: assert property (nvmReq |-> nvmAddr == SEC_BYTE_ADDR)
    else $error("security byte fetched from the wrong address");
  chk_fetch_once: assert property (nvmReq && nvmValid |=> !nvmReq)
    else $error("security byte request not dropped");
  chk_permit_load: assert property (s_load |-> ##2 backdoorEnabled == $past(permitIn, 2))
    else $error("backdoor permission wrong after load");
  chk_lock_load: assert property (s_load_calm |-> unsecured == $past(lockIn, 2))
    else $error("lock state wrong after load");
  chk_fault_lock: assert property (nvmReq && nvmValid && nvmDoubleFault
    |-> ##2 !backdoorEnabled && !unsecured)
    else $error("double fault did not secure the part");
  chk_unlock_force: assert property (backdoorUnlock && !nvmReq |-> ##[1:2] unsecured)
    else $error("backdoor unlock did not unsecure");
  chk_start_pulse: assert property (cmdStart |=> !cmdStart)
    else $error("command start longer than one cycle");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped before taken");
endmodule : flash_security_and_command_entry_asserts

bind flash_security_and_command_entry flash_security_and_command_entry_asserts u_chk (.*);

// *** test/flash_security_and_command_entry_test.sv ***
/*
  Self-checking bench for the flash security and command entry front end.
  Assumes the design answers on AXI4-Lite and fetches its byte after reset.
*/
`timescale 1ns/1ns
module flash_security_and_command_entry_test
  import flash_sec_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        nvmDoubleFault, nvmValid, nvmReq, backdoorUnlock, cmdDone, resultWe;
  logic        cmdStart, backdoorEnabled, unsecured, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, nvmByte, cmdCode, pe;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [31:0] seed = 32'h07FD635C;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
  logic [2:0]  resultIndex;
  logic [15:0] resultData, cmdData0, v;
  logic [15:0] arr [8];
  logic [17:0] nvmAddr, cmdAddr;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          starts = 0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (cmdStart === 1'b1) starts <= starts + 1;

  flash_security_and_command_entry u_dut (.*);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] expProt(input logic [7:0] b, input logic f);
    return f ? PROT_FAULT : b;
  endfunction : expProt

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results;
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check("bresp", s_axi_bresp, (a > INTMSK_OFFS) ? RESP_DECERR : RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rdat, rrsp);
    check("rdata", rdat, e);
    check("rresp", rrsp, RESP_OKAY);
  endtask : rdc

  // Outputs are flops behind the bus, so two edges pass before they are looked at.
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic boot(input logic [7:0] b, input logic f);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    while (nvmReq !== 1'b1) begin
      @(posedge core_clk);
    end
    nvmByte <= b;
    nvmDoubleFault <= f;
    nvmValid <= 1'b1;
    @(posedge core_clk);
    nvmValid <= 1'b0;
    settle();
  endtask : boot

  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {nvmDoubleFault, nvmValid, backdoorUnlock, cmdDone, resultWe} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, nvmByte, resultIndex, resultData} = '0;
    s_axi_wstrb = 4'hF;
    // Reserved bits stay erased; the last pass injects a double fault.
    for (int i = 0; i < 5; i++) begin
      boot({i[1:0], 4'hF, ~i[1:0]}, i == 4);
      pe = expProt({i[1:0], 4'hF, ~i[1:0]}, i == 4);
      check("permit", backdoorEnabled, pe[7:6] == PERMIT_ON);
      check("unsecured", unsecured, pe[1:0] == UNLOCKED);
      rdc(PROT_OFFS, {24'h0, pe});
    end
    boot(8'hBC, 1'b0);
    wr(PROT_OFFS, 32'h0);
    rdc(PROT_OFFS, 32'hBC);
    rdc(INTST_OFFS, 32'h2);
    wr(INTMSK_OFFS, 32'h2);
    settle();
    check("irq", irq, 1'b1);
    wr(INTST_OFFS, 32'h2);
    settle();
    check("irq", irq, 1'b0);
    wr(INDEX_OFFS, 32'hFFFFFFFF);
    rdc(INDEX_OFFS, 32'h7);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? (seed[15:0] & 16'hFF03) : seed[15:0];
      arr[i] = (i < PARAM_WORDS) ? v : 16'h0;
      wr(INDEX_OFFS, i);
      wr(PARAM_OFFS, {16'h0, v});
    end
    for (int i = 0; i < 8; i++) begin
      wr(INDEX_OFFS, i);
      rdc(PARAM_OFFS, {16'h0, arr[i]});
    end
    check("cmdCode", cmdCode, arr[0][15:8]);
    check("cmdAddr", cmdAddr, {arr[0][1:0], arr[1]});
    check("cmdData0", cmdData0, arr[2]);
    wr(STATUS_OFFS, 32'h0);
    settle();
    check("starts", starts, 0);
    rdc(STATUS_OFFS, 32'h80);
    wr(INTMSK_OFFS, 32'h1);
    wr(STATUS_OFFS, 32'h80);
    settle();
    check("starts", starts, 1);
    rdc(STATUS_OFFS, 32'h0);
    wr(INDEX_OFFS, 32'h2);
    wr(PARAM_OFFS, {16'h0, ~arr[2]});
    rdc(PARAM_OFFS, {16'h0, arr[2]});
    @(posedge core_clk);
    resultWe <= 1'b1;
    resultIndex <= 3'h2;
    resultData <= seed[31:16];
    @(posedge core_clk);
    resultWe <= 1'b0;
    cmdDone <= 1'b1;
    @(posedge core_clk);
    cmdDone <= 1'b0;
    settle();
    check("irq", irq, 1'b1);
    rdc(STATUS_OFFS, 32'h80);
    rdc(PARAM_OFFS, {16'h0, seed[31:16]});
    wr(INTST_OFFS, 32'h1);
    settle();
    check("irq", irq, 1'b0);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, rdat, rrsp);
    check("rresp", rrsp, RESP_DECERR);
    check("rdata", rdat, 32'h0);
    check("unsecured", unsecured, 1'b0);
    @(posedge core_clk);
    backdoorUnlock <= 1'b1;
    @(posedge core_clk);
    backdoorUnlock <= 1'b0;
    settle();
    check("unsecured", unsecured, 1'b1);
    rdc(PROT_OFFS, 32'hBE);
    results();
  end

  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule : flash_security_and_command_entry_test
